// file: uafs_defines.svh
// register offsets, field positions, reset values for the flow block
// assumes inclusion by bare name from the flow module and the top module
`ifndef UAFS_DEFINES_SVH
`define UAFS_DEFINES_SVH
`define UAFS_ADDR_W        4
`define UAFS_OFF_IER       4'h1
`define UAFS_OFF_ISR       4'h2
`define UAFS_OFF_LCR       4'h3
`define UAFS_OFF_MCR       4'h4
`define UAFS_OFF_LSR       4'h5
`define UAFS_OFF_MSR       4'h6
`define UAFS_OFF_SPR       4'h7
`define UAFS_OFF_DLL       4'h8
`define UAFS_OFF_DLM       4'h9
`define UAFS_OFF_EFR       4'hA
`define UAFS_OFF_RESUME_CHAR_ONE      4'hB
`define UAFS_OFF_RESUME_CHAR_TWO      4'hC
`define UAFS_OFF_PAUSE_CHAR_ONE     4'hD
`define UAFS_OFF_PAUSE_CHAR_TWO     4'hE
`define UAFS_OFF_FIFO      4'hF
`define UAFS_OFF_FCR       4'h0
`define UAFS_EFR_SPECIAL   5
`define UAFS_EFR_ARTS      6
`define UAFS_EFR_ACTS      7
`define UAFS_ISR_SPECIAL   4
`define UAFS_ISR_STOP      0
`define UAFS_ISR_TRIG      1
`define UAFS_IER_SPECIAL   5
`define UAFS_MCR_RTS       1
`define UAFS_MCR_DTR       0
`define UAFS_MCR_OP1       2
`define UAFS_RST_ZERO      8'h00
`define UAFS_RST_ISR       8'h01
`define UAFS_RST_LSR       8'h60
`define UAFS_RST_SPR       8'hFF
`define UAFS_RST_ENHANCED_MODE_SELECT      8'h80
`define UAFS_RST_DLM       8'h00
`define UAFS_RST_DLL       8'h01
`define UAFS_SEL_PAIR_ONE  2'h2
`define UAFS_SEL_PAIR_TWO  2'h1
`define UAFS_TRIG_LOW      7'h08
`define UAFS_TRIG_MID      7'h10
`define UAFS_TRIG_HIGH     7'h18
`endif

// file: uafs_pkg.sv
// types shared by the flow block
// assumes the defines header is compiled alongside
package uafs_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uafs_char_t;
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [3:0]              addr;
    logic [7:0]              wdata;
  } uafs_bus_t;
endpackage : uafs_pkg

// file: uafs_flow.sv
// per-channel special character, auto request and auto clear logic
// assumes characters, fifo fill and pins synchronous to sys_clk
//
// Overview of operation
// R1: with detect on, match received char to pause_char_two, store, flag bit 4
// R2: register bit 0 lines up with the received character's lsb
// R3: pair-one compare: flow control and detection both act normally
// R4: pair-two compare with detect: match dropped, stop and special flags
// R5: auto request: flag at trigger, request high at next upper level
// R6: auto request: request low once fill falls below next lower level
// R7: software must assert request low in modem control before auto works
// R8: without hardware flow control request pin follows software bit
// R9: auto clear: transmitter halts while clear input high, resumes when low
// R10: detect, auto request and auto clear enables reset to zero
// R11: divisor bytes set only at power-up, untouched by the reset pin
// R12: on reset modem status low nibble clears, high nibble inverted inputs
// R13: listed registers take their documented reset values
// R14: reset drives tx, outputs, request and ready pins to given levels
`timescale 1ns/1ps
`include "uafs_defines.svh"
module uafs_flow
  import uafs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        powerUp,
  input  wire uafs_bus_t   bus,
  output logic [7:0]       rdData,
  input  wire uafs_char_t  rxChar,
  output uafs_char_t       fifoPush,
  input  wire logic [6:0]  rxFill,
  input  wire logic        txSerialIn,
  input  wire logic        txReadyIn,
  output logic             txSerial,
  output logic             txEnable,
  output logic             transmit_ready_n,
  input  wire logic [3:0]  modemIn_n,
  output logic             requestToSend_n,
  output logic             dataTermReady_n,
  output logic             general_output_n,
  output logic             multifunction_output_n,
  output logic             irq
);
  logic [7:0] enhanced_feature_ctrl;
  logic [7:0] resume_char_one;
  logic [7:0] resume_char_two;
  logic [7:0] pause_char_one;
  logic [7:0] pause_char_two;
  logic [7:0] interrupt_enable;
  logic [7:0] interrupt_status;
  logic [7:0] line_control;
  logic [7:0] modem_control;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic [7:0] scratchpad;
  logic [7:0] fifo_control;
  logic [7:0] divisor_high;
  logic [7:0] divisorLow;
  logic [3:0] modemPrev;
  logic       matchTwo;
  logic       pairTwo;
  logic       detectOn;
  logic       trigHit;
  logic [7:0] next_rdData;
  logic [7:0] irqMask;
  logic [3:0] modemDelta;
  logic       modemArmed;

  assign detectOn = enhanced_feature_ctrl[`UAFS_EFR_SPECIAL];
  assign pairTwo  = enhanced_feature_ctrl[1:0] == `UAFS_SEL_PAIR_TWO;
  assign matchTwo = rxChar.valid && rxChar.data == pause_char_two; // [R2]
  assign trigHit  = rxFill == `UAFS_TRIG_MID;
  // special flag answers to enable bit 5, not to its own bit position
  assign irqMask    = {interrupt_enable[7:5],
                       interrupt_enable[`UAFS_IER_SPECIAL],
                       interrupt_enable[3:0]}; // [R4]
  // first cycle after reset only loads history, so no false delta
  assign modemDelta = modemArmed ? (modemPrev ^ ~modemIn_n) : 4'h0; // [R12]

  // register writes, reset values from reset pin
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      enhanced_feature_ctrl <= `UAFS_RST_ZERO; // [R10] [R13]
      resume_char_one       <= `UAFS_RST_ZERO; // [R13]
      resume_char_two       <= `UAFS_RST_ZERO;
      pause_char_one        <= `UAFS_RST_ZERO;
      pause_char_two        <= `UAFS_RST_ZERO;
      interrupt_enable      <= `UAFS_RST_ZERO;
      line_control          <= `UAFS_RST_ZERO;
      modem_control         <= `UAFS_RST_ZERO;
      fifo_control          <= `UAFS_RST_ZERO;
      scratchpad            <= `UAFS_RST_SPR;
    end else if (bus.wr) begin
      if (bus.addr == `UAFS_OFF_EFR) begin
        enhanced_feature_ctrl <= bus.wdata;
      end else if (bus.addr == `UAFS_OFF_RESUME_CHAR_ONE) begin
        resume_char_one <= bus.wdata;
      end else if (bus.addr == `UAFS_OFF_RESUME_CHAR_TWO) begin
        resume_char_two <= bus.wdata;
      end else if (bus.addr == `UAFS_OFF_PAUSE_CHAR_ONE) begin
        pause_char_one <= bus.wdata;
      end else if (bus.addr == `UAFS_OFF_PAUSE_CHAR_TWO) begin
        pause_char_two <= bus.wdata;
      end else if (bus.addr == `UAFS_OFF_IER) begin
        interrupt_enable <= bus.wdata;
      end else if (bus.addr == `UAFS_OFF_LCR) begin
        line_control <= bus.wdata;
      end else if (bus.addr == `UAFS_OFF_MCR) begin
        modem_control <= bus.wdata;
      end else if (bus.addr == `UAFS_OFF_FCR) begin
        fifo_control <= bus.wdata;
      end else if (bus.addr == `UAFS_OFF_SPR) begin
        scratchpad <= bus.wdata;
      end
    end
  end

  // divisor lives on power-up only so a pin reset keeps the baud rate
  always_ff @(posedge sys_clk or posedge powerUp) begin
    if (powerUp) begin
      divisor_high <= `UAFS_RST_DLM; // [R11]
      divisorLow   <= `UAFS_RST_DLL; // [R11]
    end else if (bus.wr && bus.addr == `UAFS_OFF_DLM) begin
      divisor_high <= bus.wdata;
    end else if (bus.wr && bus.addr == `UAFS_OFF_DLL) begin
      divisorLow <= bus.wdata;
    end
  end

  // sticky status; set wins over write-one-to-clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      interrupt_status <= `UAFS_RST_ISR; // [R13]
    end else begin
      logic [7:0] setBits;
      logic [7:0] clrBits;
      setBits = 8'h00;
      clrBits = 8'h00;
      if (detectOn && matchTwo) begin
        setBits[`UAFS_ISR_SPECIAL] = 1'b1; // [R1] [R3]
        if (pairTwo) begin
          setBits[`UAFS_ISR_STOP] = 1'b1; // [R4]
        end
      end
      if (enhanced_feature_ctrl[`UAFS_EFR_ARTS] && trigHit) begin
        setBits[`UAFS_ISR_TRIG] = 1'b1; // [R5]
      end
      if (bus.wr && bus.addr == `UAFS_OFF_ISR) begin
        clrBits = bus.wdata;
      end
      interrupt_status <= (interrupt_status & ~clrBits) | setBits;
    end
  end

  // matching char reaches the fifo unless pair two consumes it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fifoPush <= '0;
    end else begin
      fifoPush.data  <= rxChar.data;
      fifoPush.valid <= rxChar.valid &&
                        !(detectOn && pairTwo && matchTwo); // [R1] [R4]
    end
  end

  // request pin: software level, overridden by fill hysteresis
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      requestToSend_n <= 1'b1; // [R14]
    end else if (!enhanced_feature_ctrl[`UAFS_EFR_ARTS] ||
                 !modem_control[`UAFS_MCR_RTS]) begin
      requestToSend_n <= !modem_control[`UAFS_MCR_RTS]; // [R7] [R8]
    end else if (rxFill >= `UAFS_TRIG_HIGH) begin
      requestToSend_n <= 1'b1; // [R5]
    end else if (rxFill < `UAFS_TRIG_LOW) begin
      requestToSend_n <= 1'b0; // [R6]
    end
  end

  // transmit gating on clear input
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      txSerial         <= 1'b1; // [R14]
      txEnable         <= 1'b0;
      transmit_ready_n <= 1'b0; // [R14]
    end else begin
      txSerial         <= txSerialIn;
      txEnable         <= !(enhanced_feature_ctrl[`UAFS_EFR_ACTS] &&
                            modemIn_n[0]); // [R9]
      transmit_ready_n <= !txReadyIn;
    end
  end

  // other pins, status and interrupt line
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dataTermReady_n        <= 1'b1; // [R14]
      general_output_n       <= 1'b1;
      multifunction_output_n <= 1'b1;
      irq                    <= 1'b0;
      line_status            <= `UAFS_RST_LSR;
      modem_status           <= `UAFS_RST_ZERO;
      modemPrev              <= 4'h0;
      modemArmed             <= 1'b0;
    end else begin
      modemArmed             <= 1'b1;
      dataTermReady_n        <= !modem_control[`UAFS_MCR_DTR];
      general_output_n       <= !modem_control[`UAFS_MCR_OP1];
      multifunction_output_n <= 1'b1;
      irq <= |(interrupt_status & irqMask); // [R4]
      line_status            <= `UAFS_RST_LSR;
      modemPrev              <= ~modemIn_n;
      modem_status[7:4]      <= ~modemIn_n; // [R12]
      if (bus.rd && bus.addr == `UAFS_OFF_MSR) begin
        modem_status[3:0] <= modemDelta;
      end else begin
        modem_status[3:0] <= modem_status[3:0] | modemDelta;
      end
    end
  end

  always_comb begin
    next_rdData = 8'h00;
    if (bus.addr == `UAFS_OFF_EFR) begin
      next_rdData = enhanced_feature_ctrl;
    end else if (bus.addr == `UAFS_OFF_RESUME_CHAR_ONE) begin
      next_rdData = resume_char_one;
    end else if (bus.addr == `UAFS_OFF_RESUME_CHAR_TWO) begin
      next_rdData = resume_char_two;
    end else if (bus.addr == `UAFS_OFF_PAUSE_CHAR_ONE) begin
      next_rdData = pause_char_one;
    end else if (bus.addr == `UAFS_OFF_PAUSE_CHAR_TWO) begin
      next_rdData = pause_char_two;
    end else if (bus.addr == `UAFS_OFF_IER) begin
      next_rdData = interrupt_enable;
    end else if (bus.addr == `UAFS_OFF_ISR) begin
      next_rdData = interrupt_status;
    end else if (bus.addr == `UAFS_OFF_LCR) begin
      next_rdData = line_control;
    end else if (bus.addr == `UAFS_OFF_MCR) begin
      next_rdData = modem_control;
    end else if (bus.addr == `UAFS_OFF_LSR) begin
      next_rdData = line_status;
    end else if (bus.addr == `UAFS_OFF_MSR) begin
      next_rdData = modem_status;
    end else if (bus.addr == `UAFS_OFF_SPR) begin
      next_rdData = scratchpad;
    end else if (bus.addr == `UAFS_OFF_DLL) begin
      next_rdData = divisorLow;
    end else if (bus.addr == `UAFS_OFF_DLM) begin
      next_rdData = divisor_high;
    end else if (bus.addr == `UAFS_OFF_FIFO) begin
      next_rdData = {1'b0, rxFill};
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdData <= 8'h00;
    end else if (bus.rd) begin
      rdData <= next_rdData;
    end else begin
      rdData <= 8'h00;
    end
  end

  property p_pair_two_drop;
    @(posedge sys_clk) disable iff (reset)
    (detectOn && pairTwo && matchTwo) |=> !fifoPush.valid;
  endproperty
  a_pair_two_drop: assert property (p_pair_two_drop) // [R4]
    else $error("pair two stop char reached fifo");

  property p_special_flag;
    @(posedge sys_clk) disable iff (reset)
    (detectOn && matchTwo) |=> interrupt_status[`UAFS_ISR_SPECIAL];
  endproperty
  a_special_flag: assert property (p_special_flag) // [R1]
    else $error("special flag not set");

  property p_rts_high;
    @(posedge sys_clk) disable iff (reset)
    (enhanced_feature_ctrl[`UAFS_EFR_ARTS] && modem_control[`UAFS_MCR_RTS]
     && rxFill >= `UAFS_TRIG_HIGH) |=> requestToSend_n;
  endproperty
  a_rts_high: assert property (p_rts_high) // [R5]
    else $error("request not released at upper level");

  property p_rts_low;
    @(posedge sys_clk) disable iff (reset)
    (modem_control[`UAFS_MCR_RTS] && rxFill < `UAFS_TRIG_LOW) |=>
      !requestToSend_n;
  endproperty
  a_rts_low: assert property (p_rts_low) // [R6]
    else $error("request not asserted below lower level");

  property p_rts_manual;
    @(posedge sys_clk) disable iff (reset)
    !enhanced_feature_ctrl[`UAFS_EFR_ARTS] |=>
      requestToSend_n == !$past(modem_control[`UAFS_MCR_RTS]);
  endproperty
  a_rts_manual: assert property (p_rts_manual) // [R8]
    else $error("request pin not following software");

  property p_cts_halt;
    @(posedge sys_clk) disable iff (reset)
    (enhanced_feature_ctrl[`UAFS_EFR_ACTS] && modemIn_n[0]) |=> !txEnable;
  endproperty
  a_cts_halt: assert property (p_cts_halt) // [R9]
    else $error("transmitter not halted");

  property p_msr_high;
    @(posedge sys_clk) disable iff (reset)
    !reset |=> modem_status[7:4] == ~$past(modemIn_n);
  endproperty
  a_msr_high: assert property (p_msr_high) // [R12]
    else $error("modem status high nibble wrong");

  property p_pair_one_store;
    @(posedge sys_clk) disable iff (reset)
    (detectOn && !pairTwo && matchTwo) |=> fifoPush.valid;
  endproperty
  a_pair_one_store: assert property (p_pair_one_store) // [R3]
    else $error("matched char not stored");

  property p_special_irq;
    @(posedge sys_clk) disable iff (reset)
    (interrupt_status[`UAFS_ISR_SPECIAL] &&
     interrupt_enable[`UAFS_IER_SPECIAL]) |=> irq;
  endproperty
  a_special_irq: assert property (p_special_irq) // [R4]
    else $error("special interrupt not raised");
endmodule : uafs_flow

// file: uafs_remote.sv
// remote serial end: received characters and modem handshake lines
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ps
module uafs_remote
  import uafs_pkg::*;
(
  input  wire logic  sys_clk,
  output uafs_char_t rxChar,
  output logic [3:0] modemIn_n
);
  initial begin
    rxChar    = '0;
    modemIn_n = 4'hA;
  end
  // released data shows the inverse so a stale byte never looks valid
  task send(input logic [7:0] b);
    @(posedge sys_clk) rxChar <= uafs_char_t'{1'b1, b};
    @(posedge sys_clk) rxChar <= uafs_char_t'{1'b0, ~b};
  endtask : send
  task cts(input logic lvl);
    @(posedge sys_clk) modemIn_n[0] <= lvl;
  endtask : cts
  task lines(input logic [3:0] v);
    @(posedge sys_clk) modemIn_n <= v;
  endtask : lines
endmodule : uafs_remote

// file: tb_uafs_flow.sv
// self-checking bench: reads and fifo pushes scoreboarded via queues
// assumes the remote model supplies received chars and modem lines
`timescale 1ns/1ps
`include "uafs_defines.svh"
module tb_uafs_flow import uafs_pkg::*;;
  logic       sys_clk, reset, powerUp, txSerialIn, txReadyIn, rdLast;
  uafs_bus_t  bus;
  uafs_char_t rxChar, fifoPush;
  logic [7:0] rdData, d;
  logic [6:0] rxFill;
  logic [3:0] modemIn_n;
  logic       txSerial, txEnable, transmit_ready_n, requestToSend_n;
  logic       dataTermReady_n, general_output_n, multifunction_output_n;
  logic       irq;
  logic [7:0] rdQ[$], pushQ[$];
  int         err_count, total_checks;
  logic [7:0] rstv[16] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60,
    8'h50, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [6:0] fills[5] = '{7'h10, 7'h17, 7'h18, 7'h08, 7'h07};
  logic       rtsExp[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  wire  [7:0] pins = {1'b0, txSerial, general_output_n,
    multifunction_output_n, requestToSend_n, dataTermReady_n,
    transmit_ready_n, irq};
  wire  [7:0] outs = {5'h0, general_output_n, requestToSend_n,
    dataTermReady_n};

  uafs_flow u_uafs_flow (.sys_clk(sys_clk), .reset(reset),
    .powerUp(powerUp), .bus(bus), .rdData(rdData), .rxChar(rxChar),
    .fifoPush(fifoPush), .rxFill(rxFill), .txSerialIn(txSerialIn),
    .txReadyIn(txReadyIn), .txSerial(txSerial), .txEnable(txEnable),
    .transmit_ready_n(transmit_ready_n), .modemIn_n(modemIn_n),
    .requestToSend_n(requestToSend_n), .dataTermReady_n(dataTermReady_n),
    .general_output_n(general_output_n),
    .multifunction_output_n(multifunction_output_n), .irq(irq));
  uafs_remote u_uafs_remote (.sys_clk(sys_clk), .rxChar(rxChar),
    .modemIn_n(modemIn_n));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge sys_clk) bus.wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    @(posedge sys_clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk) bus.rd <= 1'b0;
  endtask : rd
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cyc
  task rst(input logic p);
    @(posedge sys_clk) begin
      reset   <= ~p;
      powerUp <= p;
    end
    @(posedge sys_clk) begin
      reset   <= 1'b0;
      powerUp <= 1'b0;
    end
  endtask : rst

  // results are due one cycle after the read strobe or the char pulse
  always @(posedge sys_clk) rdLast <= bus.rd;
  always @(negedge sys_clk) begin
    if (rdLast === 1'b1)
      chk(rdData, rdQ.size() > 0 ? rdQ.pop_front() : 8'hXX);
    if (fifoPush.valid === 1'b1)
      chk(fifoPush.data, pushQ.size() > 0 ? pushQ.pop_front() : 8'hXX);
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    results;
  end

  initial begin
    bus = '0;
    rxFill = 7'h00;
    txSerialIn = 1'b1;
    txReadyIn = 1'b1;
    reset = 1'b1;
    powerUp = 1'b1;
    err_count = 0;
    total_checks = 0;
    d = 8'($urandom(32'h7D8E17DE));
    cyc(2);
    chk(pins, 8'h7C);
    @(posedge sys_clk) begin
      reset   <= 1'b0;
      powerUp <= 1'b0;
    end
    for (int i = 0; i < 16; i++) rd(4'(i), rstv[i]);
    for (int i = 11; i < 14; i++) begin
      d = 8'($urandom) | 8'h80;
      wr(4'(i), d);
      rd(4'(i), d);
    end
    wr(`UAFS_OFF_DLL, 8'h34);
    wr(`UAFS_OFF_DLM, 8'h12);
    rst(1'b0);
    rd(`UAFS_OFF_DLL, 8'h34);
    rd(`UAFS_OFF_DLM, 8'h12);
    rd(`UAFS_OFF_RESUME_CHAR_ONE, 8'h00);
    rd(`UAFS_OFF_MSR, 8'h50);
    rst(1'b1);
    rd(`UAFS_OFF_DLL, 8'h01);
    rd(`UAFS_OFF_DLM, 8'h00);
    // reversed bit order of the match value must not hit
    wr(`UAFS_OFF_PAUSE_CHAR_TWO, 8'h01);
    wr(`UAFS_OFF_ISR, 8'hFF);
    wr(`UAFS_OFF_IER, 8'h20);
    wr(`UAFS_OFF_EFR, 8'h20);
    pushQ.push_back(8'h80);
    u_uafs_remote.send(8'h80);
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      if (d == 8'h01) d = 8'h02;
      pushQ.push_back(d);
      u_uafs_remote.send(d);
    end
    rd(`UAFS_OFF_ISR, 8'h00);
    pushQ.push_back(8'h01);
    u_uafs_remote.send(8'h01);
    rd(`UAFS_OFF_ISR, 8'h10);
    cyc(2);
    chk({7'h0, irq}, 8'h01);
    wr(`UAFS_OFF_IER, 8'h10);
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    for (int s = 1; s <= 2; s++) begin
      wr(`UAFS_OFF_ISR, 8'hFF);
      wr(`UAFS_OFF_EFR, 8'h20 | 8'(s));
      if (s == 2) pushQ.push_back(8'h01);
      u_uafs_remote.send(8'h01);
      rd(`UAFS_OFF_ISR, s == 2 ? 8'h10 : 8'h11);
    end
    wr(`UAFS_OFF_EFR, 8'h00);
    wr(`UAFS_OFF_MCR, 8'h07);
    cyc(3);
    chk(outs, 8'h00);
    wr(`UAFS_OFF_MCR, 8'h00);
    wr(`UAFS_OFF_EFR, 8'h40);
    @(posedge sys_clk) rxFill <= 7'h07;
    cyc(3);
    chk(outs, 8'h07);
    wr(`UAFS_OFF_ISR, 8'hFF);
    wr(`UAFS_OFF_MCR, 8'h02);
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk) rxFill <= fills[i];
      cyc(3);
      chk({7'h0, requestToSend_n}, {7'h0, rtsExp[i]});
      if (i == 0) rd(`UAFS_OFF_ISR, 8'h02);
    end
    // any fill between the lower and upper levels keeps the request low once it has gone low
    d = 8'($urandom);
    @(posedge sys_clk) rxFill <= 7'h08 + 7'(d[3:0]);
    cyc(3);
    chk({7'h0, requestToSend_n}, 8'h00);
    wr(`UAFS_OFF_EFR, 8'h80);
    u_uafs_remote.cts(1'b1);
    cyc(3);
    chk({7'h0, txEnable}, 8'h00);
    u_uafs_remote.cts(1'b0);
    cyc(3);
    chk({7'h0, txEnable}, 8'h01);
    wr(`UAFS_OFF_EFR, 8'h00);
    u_uafs_remote.cts(1'b1);
    cyc(3);
    chk({7'h0, txEnable}, 8'h01);
    // clear input toggled since the last status read, now held high
    rd(`UAFS_OFF_MSR, 8'h41);
    d = 8'($urandom);
    u_uafs_remote.lines(d[3:0]);
    cyc(2);
    rd(`UAFS_OFF_MSR, {~d[3:0], d[3:0] ^ 4'hB});
    d = 8'($urandom);
    @(posedge sys_clk) begin
      txSerialIn <= d[0];
      txReadyIn  <= d[1];
    end
    cyc(3);
    chk({6'h0, txSerial, transmit_ready_n}, {6'h0, d[0], ~d[1]});
    cyc(4);
    chk(8'(rdQ.size() + pushQ.size()), 8'h00);
    results;
  end
endmodule : tb_uafs_flow
